// *** tdm_switch_timing_control.sv ***
/*
 * Device control register with its timing front end: mode, PLL gate, input source,
 * clock and pulse polarity, pulse position and rate decode, behind an AXI4-Lite slave.
 * Assumes timing pins synchronous to CLK and a master that keeps one write and one read open.
 */
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module tdm_switch_timing_control
	import tdm_timing_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [31:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [31:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic OSCILLATOR_ENABLE,
	input wire logic INPUT_CLOCK_PIN,
	input wire logic INPUT_FRAME_PULSE_PIN,
	input wire logic CLOCK_OUTPUT_2,
	input wire logic FRAME_PULSE_OUTPUT_2,
	output logic SLAVE_MODE,
	output logic SLAVE_PLL_ACTIVE,
	output logic LOOPBACK_ACTIVE,
	output logic LOW_OUTPUT_SOURCE_INPUT,
	output logic HIGH_OUTPUT_SOURCE_REFERENCE,
	output logic FRAME_BOUNDARY,
	output logic [8:0] FRAME_PULSE_WIDTH_NS,
	output logic [14:0] INPUT_CLOCK_KHZ,
	output logic INPUT_RATE_RESERVED,
	output logic [4:0] LOW_CONTROLS
);

	device_control_t ctrl;
	timing_status_t status;
	logic aw_held;
	logic w_held;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic do_write;
	logic next_aw_held;
	logic next_w_held;
	logic next_bvalid;
	logic next_rvalid;
	logic [15:0] write_value;
	logic [31:0] read_data;
	logic [1:0] read_resp;
	logic is_slave_now;
	logic loop_now;
	logic src_clk;
	logic src_fp;
	logic prev_clk;
	logic fp_last_edge;
	logic boundary_edge;
	logic fp_active;
	logic frame_hit;

	// Write channel bookkeeping and the next read valid
	always_comb begin
		do_write = aw_held && w_held && !BVALID;
		next_aw_held = (aw_held || (AWVALID && AWREADY)) && !do_write;
		next_w_held = (w_held || (WVALID && WREADY)) && !do_write;
		next_bvalid = do_write || (BVALID && !BREADY);
		next_rvalid = (ARVALID && ARREADY) || (RVALID && !RREADY);
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= RESP_OKAY;
			wr_addr <= 32'h0000_0000;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			AWREADY <= !next_aw_held && !next_bvalid;
			WREADY <= !next_w_held && !next_bvalid;
			BVALID <= next_bvalid;
			if (AWVALID && AWREADY) begin
				wr_addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				wr_data <= WDATA;
				wr_strb <= WSTRB;
			end
			if (do_write) begin
				BRESP <= ({wr_addr[31:2], 2'b00} == DEVICE_CONTROL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Byte lanes applied to the control word; reserved bits forced to zero
	always_comb begin
		write_value = ctrl;
		if (wr_strb[0]) begin
			write_value[7:0] = wr_data[7:0];
		end
		if (wr_strb[1]) begin
			write_value[15:8] = wr_data[15:8];
		end
		write_value = write_value & ~RESERVED_MASK;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl <= DEVICE_CONTROL_RESET;
		end else if (do_write && {wr_addr[31:2], 2'b00} == DEVICE_CONTROL_OFFSET) begin
			ctrl <= write_value;
		end
	end

	// Read channel
	always_comb begin
		read_data = 32'h0000_0000;
		read_resp = RESP_OKAY;
		if ({ARADDR[31:2], 2'b00} == DEVICE_CONTROL_OFFSET) begin
			read_data = {16'h0000, ctrl};
		end else if ({ARADDR[31:2], 2'b00} == TIMING_STATUS_OFFSET) begin
			read_data = {16'h0000, status};
		end else begin
			read_resp = RESP_SLVERR;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= RESP_OKAY;
		end else begin
			ARREADY <= !next_rvalid;
			RVALID <= next_rvalid;
			if (ARVALID && ARREADY) begin
				RDATA <= read_data;
				RRESP <= read_resp;
			end
		end
	end

	// Mode, PLL gate and output source decode
	always_comb begin
		is_slave_now = ctrl.operation_mode_sel != MODE_MASTER;
		loop_now = ctrl.input_timing_loopback && !is_slave_now;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			SLAVE_MODE <= 1'b0;
			SLAVE_PLL_ACTIVE <= 1'b0;
			LOOPBACK_ACTIVE <= 1'b0;
			LOW_OUTPUT_SOURCE_INPUT <= 1'b0;
			HIGH_OUTPUT_SOURCE_REFERENCE <= 1'b0;
			LOW_CONTROLS <= 5'h00;
		end else begin
			SLAVE_MODE <= is_slave_now;
			SLAVE_PLL_ACTIVE <= is_slave_now && ctrl.slave_pll_enable && OSCILLATOR_ENABLE;
			LOOPBACK_ACTIVE <= loop_now;
			LOW_OUTPUT_SOURCE_INPUT <= is_slave_now && ctrl.slave_pll_enable && OSCILLATOR_ENABLE;
			HIGH_OUTPUT_SOURCE_REFERENCE <= is_slave_now && ctrl.slave_pll_enable && OSCILLATOR_ENABLE;
			LOW_CONTROLS <= ctrl.low_controls;
		end
	end

	// Rate decode
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			FRAME_PULSE_WIDTH_NS <= PULSE_NS_16M;
			INPUT_CLOCK_KHZ <= CLOCK_KHZ_16M;
			INPUT_RATE_RESERVED <= 1'b0;
		end else begin
			case (ctrl.input_rate_sel)
				RATE_16M: begin
					FRAME_PULSE_WIDTH_NS <= PULSE_NS_16M;
					INPUT_CLOCK_KHZ <= CLOCK_KHZ_16M;
					INPUT_RATE_RESERVED <= 1'b0;
				end
				RATE_8M: begin
					FRAME_PULSE_WIDTH_NS <= PULSE_NS_8M;
					INPUT_CLOCK_KHZ <= CLOCK_KHZ_8M;
					INPUT_RATE_RESERVED <= 1'b0;
				end
				RATE_4M: begin
					FRAME_PULSE_WIDTH_NS <= PULSE_NS_4M;
					INPUT_CLOCK_KHZ <= CLOCK_KHZ_4M;
					INPUT_RATE_RESERVED <= 1'b0;
				end
				default: begin
					FRAME_PULSE_WIDTH_NS <= 9'h000;
					INPUT_CLOCK_KHZ <= 15'h0000;
					INPUT_RATE_RESERVED <= 1'b1;
				end
			endcase
		end
	end

	// Input timing source, sampled once
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			src_clk <= 1'b0;
			src_fp <= 1'b0;
			prev_clk <= 1'b0;
		end else begin
			src_clk <= loop_now ? CLOCK_OUTPUT_2 : INPUT_CLOCK_PIN;
			src_fp <= loop_now ? FRAME_PULSE_OUTPUT_2 : INPUT_FRAME_PULSE_PIN;
			prev_clk <= src_clk;
		end
	end

	// Frame boundary detection
	always_comb begin
		boundary_edge = ctrl.input_clock_polarity ? (src_clk && !prev_clk) : (!src_clk && prev_clk);
		fp_active = src_fp == ctrl.frame_pulse_polarity;
		frame_hit = boundary_edge && fp_active && (!ctrl.frame_pulse_position || !fp_last_edge);
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			fp_last_edge <= 1'b0;
			FRAME_BOUNDARY <= 1'b0;
		end else begin
			if (boundary_edge) begin
				fp_last_edge <= fp_active;
			end
			FRAME_BOUNDARY <= frame_hit;
		end
	end

	// Status word
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			status <= '0;
		end else begin
			if (frame_hit) begin
				status.frame_count <= status.frame_count + 8'h01;
			end
			status.slave_mode <= is_slave_now;
			status.pll_active <= is_slave_now && ctrl.slave_pll_enable && OSCILLATOR_ENABLE;
			status.loopback_active <= loop_now;
			status.split_outputs <= is_slave_now && ctrl.slave_pll_enable && OSCILLATOR_ENABLE;
			status.rate_reserved <= ctrl.input_rate_sel == 2'h3;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	master_no_pll_a: assert property (!is_slave_now |=> !SLAVE_PLL_ACTIVE)
		else $error("PLL active in master mode");
	split_match_a: assert property (LOW_OUTPUT_SOURCE_INPUT == SLAVE_PLL_ACTIVE && HIGH_OUTPUT_SOURCE_REFERENCE == SLAVE_PLL_ACTIVE)
		else $error("Output source split does not follow PLL state");
	slave_mode_a: assert property (is_slave_now |=> SLAVE_MODE && !LOOPBACK_ACTIVE)
		else $error("Slave mode not shown or loopback not ignored");
	ext_source_a: assert property (!loop_now |=> src_clk == $past(INPUT_CLOCK_PIN) && src_fp == $past(INPUT_FRAME_PULSE_PIN))
		else $error("External pins not used as input timing");
	loop_source_a: assert property (loop_now |=> src_clk == $past(CLOCK_OUTPUT_2) && src_fp == $past(FRAME_PULSE_OUTPUT_2))
		else $error("Loop-back source not used");
	pulse_start_a: assert property (ctrl.frame_pulse_position && fp_last_edge && boundary_edge |=> !FRAME_BOUNDARY)
		else $error("Boundary flagged inside a started pulse");
	clock_edge_a: assert property (FRAME_BOUNDARY |-> $past(ctrl.input_clock_polarity) ? $past(src_clk && !prev_clk) : $past(!src_clk && prev_clk))
		else $error("Boundary on wrong clock edge");
	pulse_level_a: assert property (FRAME_BOUNDARY |-> $past(src_fp) == $past(ctrl.frame_pulse_polarity))
		else $error("Boundary with inactive frame pulse");
	rate_fast_a: assert property (ctrl.input_rate_sel == RATE_16M |=> FRAME_PULSE_WIDTH_NS == 9'h03D && INPUT_CLOCK_KHZ == 15'h4000)
		else $error("Rate 00 decoded wrongly");
	rate_slow_a: assert property (ctrl.input_rate_sel == RATE_4M |=> FRAME_PULSE_WIDTH_NS == 9'h0F4 && !INPUT_RATE_RESERVED)
		else $error("Rate 10 decoded wrongly");
	reset_clear_a: assert property (disable iff (1'b0) SYS_RST |=> ctrl == 16'h0000 && !BVALID && !RVALID)
		else $error("Control not cleared by reset");
	reserved_zero_a: assert property (ctrl.reserved == 2'h0)
		else $error("Reserved control bits set");
	write_resp_a: assert property (do_write |=> BVALID) else $error("Write response missing");
	read_resp_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("Read response missing or address still accepted");
	pll_on_a: assert property (is_slave_now && ctrl.slave_pll_enable && OSCILLATOR_ENABLE |=> SLAVE_PLL_ACTIVE)
		else $error("PLL not enabled in slave mode");
	rate_mid_a: assert property (ctrl.input_rate_sel == RATE_8M |=> FRAME_PULSE_WIDTH_NS == PULSE_NS_8M)
		else $error("Rate 01 decoded wrongly");
	rate_resv_a: assert property (ctrl.input_rate_sel == 2'h3 |=> INPUT_RATE_RESERVED && INPUT_CLOCK_KHZ == 15'h0000)
		else $error("Reserved rate not flagged");

	write_seen_c: cover property (do_write && {wr_addr[31:2], 2'b00} == DEVICE_CONTROL_OFFSET);
	loop_seen_c: cover property (LOOPBACK_ACTIVE && FRAME_BOUNDARY);
	pll_seen_c: cover property (SLAVE_PLL_ACTIVE ##1 FRAME_BOUNDARY);
	start_pos_c: cover property (ctrl.frame_pulse_position && FRAME_BOUNDARY);
	slave_seen_c: cover property (SLAVE_MODE && !SLAVE_PLL_ACTIVE);

endmodule

// *** tdm_switch_timing_control_tb.sv ***
/*
 * Self-checking bench for the timing control block: register bus, decode and frame detection.
 * Assumes the timing source model and the package; control sits at byte 0x0.
 */
`timescale 1ns/1ps
module tdm_switch_timing_control_tb
	import tdm_timing_pkg::*;
;
	logic CLK = 1'b0, SYS_RST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [31:0] AWADDR = 32'h0000_0000, WDATA = 32'h0000_0000, ARADDR = 32'h0000_0000;
	logic [3:0] WSTRB = 4'hF;
	logic OSCILLATOR_ENABLE = 1'b0, run = 1'b0, loop = 1'b0, rise = 1'b0, fph = 1'b1, wide = 1'b0;
	logic INPUT_CLOCK_PIN, INPUT_FRAME_PULSE_PIN, CLOCK_OUTPUT_2, FRAME_PULSE_OUTPUT_2;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SLAVE_MODE, SLAVE_PLL_ACTIVE, LOOPBACK_ACTIVE;
	logic LOW_OUTPUT_SOURCE_INPUT, HIGH_OUTPUT_SOURCE_REFERENCE, FRAME_BOUNDARY, INPUT_RATE_RESERVED;
	logic [1:0] BRESP, RRESP, r;
	logic p;
	logic [31:0] RDATA, d, q;
	logic [8:0] FRAME_PULSE_WIDTH_NS;
	logic [14:0] INPUT_CLOCK_KHZ;
	logic [4:0] LOW_CONTROLS, phase;
	logic [15:0] fcfg [8] = '{16'h0080, 16'h0180, 16'h0380, 16'h0000, 16'h0000, 16'h0080, 16'h0480, 16'h0080};
	logic [3:0] fsrc [8] = '{4'h2, 4'h7, 4'h7, 4'h0, 4'h2, 4'h6, 4'hA, 4'hA};
	int fexp [8] = '{1, 2, 1, 1, 3, 0, 1, 0};
	int n_mismatch = 0, checked = 0, cyc = 0, cnt;

	tdm_switch_timing_control i_tdm_switch_timing_control (.CLK(CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .OSCILLATOR_ENABLE(OSCILLATOR_ENABLE),
		.INPUT_CLOCK_PIN(INPUT_CLOCK_PIN), .INPUT_FRAME_PULSE_PIN(INPUT_FRAME_PULSE_PIN),
		.CLOCK_OUTPUT_2(CLOCK_OUTPUT_2), .FRAME_PULSE_OUTPUT_2(FRAME_PULSE_OUTPUT_2), .SLAVE_MODE(SLAVE_MODE),
		.SLAVE_PLL_ACTIVE(SLAVE_PLL_ACTIVE), .LOOPBACK_ACTIVE(LOOPBACK_ACTIVE),
		.LOW_OUTPUT_SOURCE_INPUT(LOW_OUTPUT_SOURCE_INPUT),
		.HIGH_OUTPUT_SOURCE_REFERENCE(HIGH_OUTPUT_SOURCE_REFERENCE), .FRAME_BOUNDARY(FRAME_BOUNDARY),
		.FRAME_PULSE_WIDTH_NS(FRAME_PULSE_WIDTH_NS), .INPUT_CLOCK_KHZ(INPUT_CLOCK_KHZ),
		.INPUT_RATE_RESERVED(INPUT_RATE_RESERVED), .LOW_CONTROLS(LOW_CONTROLS));
	tdm_timing_source i_tdm_timing_source (.clk(CLK), .rst(SYS_RST), .run(run), .loop(loop), .rise(rise),
		.fp_high(fph), .wide(wide), .pin_clk(INPUT_CLOCK_PIN), .pin_fp(INPUT_FRAME_PULSE_PIN),
		.lp_clk(CLOCK_OUTPUT_2), .lp_fp(FRAME_PULSE_OUTPUT_2), .phase(phase));

	initial begin
		forever #50 CLK = ~CLK;
	end

	function automatic logic [8:0] exp_ns(input logic [1:0] c);
		return c == 2'h0 ? 9'h03D : c == 2'h1 ? 9'h07A : c == 2'h2 ? 9'h0F4 : 9'h000;
	endfunction

	function automatic logic [14:0] exp_khz(input logic [1:0] c);
		return c == 2'h0 ? 15'h4000 : c == 2'h1 ? 15'h2000 : c == 2'h2 ? 15'h1000 : 15'h0000;
	endfunction

	task automatic results;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Write with address and data offered together, each released once taken
	task automatic axw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (!BVALID);
		rs = BRESP;
		BREADY <= 1'b0;
		@(posedge CLK);
	endtask

	task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge CLK);
			if (ARREADY) ARVALID <= 1'b0;
		end while (!RVALID);
		v = RDATA;
		rs = RRESP;
		RREADY <= 1'b0;
		@(posedge CLK);
	endtask

	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			results;
		end
	end

	initial begin
		void'($urandom(19));
		repeat (5) @(posedge CLK);
		SYS_RST <= 1'b0;
		repeat (2) @(posedge CLK);
		axr(DEVICE_CONTROL_OFFSET, q, r);
		chk(q, 32'h0000_0000);
		chk(32'(FRAME_PULSE_WIDTH_NS), 32'h0000_003D);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			axw(DEVICE_CONTROL_OFFSET, 32'(i) << 5, r);
			repeat (2) @(posedge CLK);
			chk(32'(FRAME_PULSE_WIDTH_NS), 32'(exp_ns(i[1:0])));
			chk(32'(INPUT_CLOCK_KHZ), 32'(exp_khz(i[1:0])));
			chk(32'(INPUT_RATE_RESERVED), 32'(i == 3));
		end
		$display("test rates done");
		for (int i = 0; i < 24; i++) begin
			d = (i == 0) ? 32'h0000_3FFF : {18'h0_0000, 14'($urandom)};
			if (d[10]) begin
				d[6:5] = 2'h0;
			end
			OSCILLATOR_ENABLE <= 1'($urandom_range(1));
			axw(DEVICE_CONTROL_OFFSET, d, r);
			chk(32'(r), 32'(RESP_OKAY));
			axr(DEVICE_CONTROL_OFFSET, q, r);
			chk(q, d & 32'h0000_3FFF);
			repeat (2) @(posedge CLK);
			p = d[12:11] != 2'h0 && d[13] && OSCILLATOR_ENABLE;
			chk(32'(SLAVE_MODE), 32'(d[12:11] != 2'h0));
			chk(32'(SLAVE_PLL_ACTIVE), 32'(p));
			chk(32'(LOW_OUTPUT_SOURCE_INPUT), 32'(p));
			chk(32'(HIGH_OUTPUT_SOURCE_REFERENCE), 32'(p));
			chk(32'(LOOPBACK_ACTIVE), 32'(d[10] && d[12:11] == 2'h0));
			chk(32'(LOW_CONTROLS), 32'(d[4:0]));
			axr(TIMING_STATUS_OFFSET, q, r);
			chk(q, {27'h000_0000, d[12:11] != 2'h0, p, d[10] && d[12:11] == 2'h0, p, d[6:5] == 2'h3});
			chk(32'(r), 32'(RESP_OKAY));
		end
		$display("test random done");
		axw(32'h0000_0008, 32'h0000_0001, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axw(TIMING_STATUS_OFFSET, 32'h0000_0001, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axr(32'h0000_0008, q, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axr(DEVICE_CONTROL_OFFSET, q, r);
		chk(q, d & 32'h0000_3FFF);
		$display("test errors done");
		run <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			// Master mode, rate 00, reserved bits zero
			axw(DEVICE_CONTROL_OFFSET, 32'(fcfg[i]), r);
			{loop, rise, fph, wide} <= fsrc[i];
			repeat (40) @(posedge CLK);
			while (phase != 5'h10) @(posedge CLK);
			cnt = 0;
			repeat (128) begin
				@(posedge CLK);
				cnt += int'(FRAME_BOUNDARY === 1'b1);
			end
			chk(32'(cnt), 32'(fexp[i] * 4));
		end
		$display("test frames done");
		results;
	end
endmodule

// *** tdm_timing_pkg.sv ***
/*
 * Constants, register layout and carrier types for the TDM switch timing control block.
 * Assumes an AXI4-Lite master with 32-bit data and a 10 MHz system clock.
 */
package tdm_timing_pkg;

	localparam logic [31:0] DEVICE_CONTROL_OFFSET = 32'h0000_0000;
	localparam logic [31:0] TIMING_STATUS_OFFSET = 32'h0000_0004;
	localparam logic [15:0] DEVICE_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] RESERVED_MASK = 16'hC000;

	localparam logic [1:0] MODE_MASTER = 2'h0;

	localparam logic [1:0] RATE_16M = 2'h0;
	localparam logic [1:0] RATE_8M = 2'h1;
	localparam logic [1:0] RATE_4M = 2'h2;

	localparam logic [8:0] PULSE_NS_16M = 9'h03D;
	localparam logic [8:0] PULSE_NS_8M = 9'h07A;
	localparam logic [8:0] PULSE_NS_4M = 9'h0F4;
	localparam logic [14:0] CLOCK_KHZ_16M = 15'h4000;
	localparam logic [14:0] CLOCK_KHZ_8M = 15'h2000;
	localparam logic [14:0] CLOCK_KHZ_4M = 15'h1000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] reserved;
		logic slave_pll_enable;
		logic [1:0] operation_mode_sel;
		logic input_timing_loopback;
		logic frame_pulse_position;
		logic input_clock_polarity;
		logic frame_pulse_polarity;
		logic [1:0] input_rate_sel;
		logic [4:0] low_controls;
	} device_control_t;

	typedef struct packed {
		logic [2:0] unused;
		logic [7:0] frame_count;
		logic slave_mode;
		logic pll_active;
		logic loopback_active;
		logic split_outputs;
		logic rate_reserved;
	} timing_status_t;

endpackage

// *** tdm_timing_source.sv ***
/*
 * Backplane timing source: frame-aligned input clock and frame pulse on the pins or the loop-back path.
 * Assumes it runs synchronous to the system clock; phase counts 32 system cycles per frame.
 */
`timescale 1ns/1ps
module tdm_timing_source (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic loop,
	input wire logic rise,
	input wire logic fp_high,
	input wire logic wide,
	output logic pin_clk,
	output logic pin_fp,
	output logic lp_clk,
	output logic lp_fp,
	output logic [4:0] phase
);
	logic tclk;
	logic act;
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			phase <= 5'h00;
		end else begin
			phase <= phase + 5'h01;
		end
	end
	// Four clock periods per frame, boundary edge at each period start; clock stands still when stopped
	assign act = run && (phase >= 5'h1E || phase <= (wide ? 5'h09 : 5'h01));
	assign tclk = run && (phase[2] ^ rise);
	// Pins held low while the loop-back path carries the timing
	assign pin_clk = !loop && tclk;
	assign pin_fp = !loop && (act ^ !fp_high);
	assign lp_clk = loop && tclk;
	assign lp_fp = loop && (act ^ !fp_high);
endmodule
